// ### design/dab_i2c_slave.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Addresses are 7-bit right-aligned; direction bit is kept apart, not compared.
// - Any programmed address is accepted; no reserved-address check.
// - Offsets below the writable length accept writes; others read-only.
// - One or two addresses, each with its own buffer.
// - A buffer flagged non-volatile is entirely read-only to the master.
// - Out-of-buffer accesses and read-only writes never touch memory.
// - Buffer is shared memory; all bus bytes handled in hardware.
// - Bytes go out in ascending order, low byte of a value first.
// - Writes start with 1 or 2 index bytes, high first; base is kept.
// - Rejected write byte dropped; NAKed if stretching on, else ACKed.
// - Reads start at stored base, advance per byte, 0xFF past the end.
module dab_i2c_slave (
  input  wire logic                        i_clk,
  input  wire logic                        i_sys_rst,
  input  wire logic                        i_scl,
  input  wire logic                        i_sda,
  output logic                             o_sda_o,
  output logic                             o_sda_oe_n,
  input  wire logic [dab_pkg::ADDR_W-1:0]  i_addr_pri,
  input  wire logic [dab_pkg::ADDR_W-1:0]  i_addr_sec,
  input  wire logic                        i_two_addr_en,
  input  wire logic                        i_sub_addr_16,
  input  wire logic                        i_stretch_en,
  input  wire logic [dab_pkg::MEM_AW-1:0]  i_pri_loc,
  input  wire logic [dab_pkg::IDX_W-1:0]   i_pri_buffer_length,
  input  wire logic [dab_pkg::IDX_W-1:0]   i_pri_writable_region_length,
  input  wire logic                        i_pri_nonvolatile,
  input  wire logic [dab_pkg::MEM_AW-1:0]  i_sec_loc,
  input  wire logic [dab_pkg::IDX_W-1:0]   i_sec_buffer_length,
  input  wire logic [dab_pkg::IDX_W-1:0]   i_sec_writable_region_length,
  input  wire logic                        i_sec_nonvolatile,
  input  wire logic [dab_pkg::MEM_AW-1:0]  i_app_addr,
  input  wire logic                        i_app_we,
  input  wire logic [dab_pkg::BYTE_W-1:0]  i_app_wdata,
  output logic      [dab_pkg::BYTE_W-1:0]  o_app_rdata,
  output logic                             o_busy
);
  import dab_pkg::*;

  // Index lies inside a region of the given length
  function automatic logic below(input logic [IDX_W-1:0] idx,
                                 input logic [IDX_W-1:0] lim);
    below = idx < lim;
  endfunction

  // Physical byte address of an index within a buffer
  function automatic logic [MEM_AW-1:0] phys(input logic [MEM_AW-1:0] loc,
                                             input logic [IDX_W-1:0]  idx);
    phys = loc + idx[MEM_AW-1:0];
  endfunction

  dab_mem_if mif ();

  logic [1:0]        scl_sync_q;
  logic [1:0]        sda_sync_q;
  logic              scl_prev_q;
  logic              sda_prev_q;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_det;
  logic              stop_det;
  logic              scl_s;
  logic              sda_s;

  dab_state_t        state_q;
  dab_kind_t         kind_q;
  logic [3:0]        bit_q;
  logic [BYTE_W-1:0] shift_q;
  logic [BYTE_W-1:0] tx_q;
  logic              sel_q;
  logic              rd_q;
  logic              ack_q;
  logic              mack_q;
  logic [IDX_W-1:0]  base_q [2];
  logic [IDX_W-1:0]  idx_q;
  logic              fetch_q;
  logic              fetch2_q;
  logic              wr_q;
  logic [MEM_AW-1:0] wr_addr_q;
  logic [BYTE_W-1:0] wr_data_q;

  logic [MEM_AW-1:0] cur_loc;
  logic [IDX_W-1:0]  cur_len;
  logic [IDX_W-1:0]  cur_wlen;
  logic              cur_nv;
  logic              hit_pri;
  logic              hit_sec;
  logic              wr_ok;
  logic              byte_done;

  // Two-stage synchronisers for both bus lines
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], i_scl};
      sda_sync_q <= {sda_sync_q[0], i_sda};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // Line events from the synchronised levels
  assign scl_s     = scl_sync_q[1];
  assign sda_s     = sda_sync_q[1];
  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign start_det = scl_s & scl_prev_q & ~sda_s & sda_prev_q;
  assign stop_det  = scl_s & scl_prev_q & sda_s & ~sda_prev_q;
  assign byte_done = scl_fall && (bit_q == BITS_PER_BYTE);

  // Settings of the buffer the transfer has selected
  assign cur_loc  = (sel_q == SEL_SEC) ? i_sec_loc : i_pri_loc;
  assign cur_len  = (sel_q == SEL_SEC) ? i_sec_buffer_length
                                       : i_pri_buffer_length;
  assign cur_wlen = (sel_q == SEL_SEC) ? i_sec_writable_region_length
                                       : i_pri_writable_region_length;
  assign cur_nv   = (sel_q == SEL_SEC) ? i_sec_nonvolatile : i_pri_nonvolatile;

  // Address match on the upper seven bits, raw value compared as given
  assign hit_pri = shift_q[BYTE_W-1:1] == i_addr_pri;
  assign hit_sec = i_two_addr_en &&
                   (shift_q[BYTE_W-1:1] == i_addr_sec);

  // A data byte may land only inside both the buffer and its writable part
  assign wr_ok = !cur_nv && below(idx_q, cur_wlen) &&
                 below(idx_q, cur_len);

  // Bit and byte sequencer
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      kind_q  <= BK_ADDR;
      bit_q   <= '0;
      shift_q <= ZERO_BYTE;
      sel_q   <= SEL_PRI;
      rd_q    <= 1'b0;
      ack_q   <= 1'b0;
      mack_q  <= 1'b0;
      idx_q   <= '0;
      fetch_q <= 1'b0;
      wr_q    <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= ZERO_BYTE;
      base_q[0] <= '0;
      base_q[1] <= '0;
    end else begin
      fetch_q <= 1'b0;
      wr_q    <= 1'b0;
      if (start_det) begin
        state_q <= ST_RX;
        kind_q  <= BK_ADDR;
        bit_q   <= '0;
        rd_q    <= 1'b0;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
      end else begin
        unique case (state_q)
          ST_IDLE, ST_WAIT: begin
          end
          ST_RX: begin
            if (scl_rise && bit_q != BITS_PER_BYTE) begin
              shift_q <= {shift_q[BYTE_W-2:0], sda_s};
              bit_q   <= bit_q + 4'h1;
            end else if (byte_done) begin
              bit_q   <= '0;
              state_q <= ST_ACK;
              ack_q   <= 1'b1;
              unique case (kind_q)
                BK_ADDR: begin
                  if (hit_pri || hit_sec) begin
                    sel_q  <= hit_pri ? SEL_PRI : SEL_SEC;
                    rd_q   <= shift_q[RW_BIT_POS];
                    kind_q <= i_sub_addr_16 ? BK_SUB_HI : BK_SUB_LO;
                    if (shift_q[RW_BIT_POS]) begin
                      idx_q   <= hit_pri ? base_q[0] : base_q[1];
                      fetch_q <= 1'b1;
                    end
                  end else begin
                    state_q <= ST_WAIT;
                    ack_q   <= 1'b0;
                  end
                end
                BK_SUB_HI: begin
                  base_q[sel_q][IDX_W-1:BYTE_W] <= shift_q;
                  kind_q <= BK_SUB_LO;
                end
                BK_SUB_LO: begin
                  base_q[sel_q][BYTE_W-1:0] <= shift_q;
                  if (!i_sub_addr_16) begin
                    base_q[sel_q][IDX_W-1:BYTE_W] <= ZERO_BYTE;
                    idx_q <= {ZERO_BYTE, shift_q};
                  end else begin
                    idx_q <= {base_q[sel_q][IDX_W-1:BYTE_W], shift_q};
                  end
                  kind_q <= BK_DATA;
                end
                BK_DATA: begin
                  idx_q <= idx_q + IDX_ONE; // Working index
                  if (wr_ok) begin
                    wr_q      <= 1'b1;
                    wr_addr_q <= phys(cur_loc, idx_q);
                    wr_data_q <= shift_q;
                  end else begin
                    ack_q <= !i_stretch_en;        // Byte dropped
                  end
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (!ack_q) begin
                state_q <= ST_WAIT;
              end else if (rd_q) begin
                state_q <= ST_TX;
              end else begin
                state_q <= ST_RX;
              end
              ack_q <= 1'b0;
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_q[2:0] == LAST_BIT) begin
                bit_q   <= '0;
                state_q <= ST_RACK;
              end else begin
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              mack_q <= !sda_s;
              if (!sda_s) begin
                idx_q   <= idx_q + IDX_ONE;       // Ascending order
                fetch_q <= 1'b1;
              end
            end else if (scl_fall) begin
              state_q <= mack_q ? ST_TX : ST_WAIT;
            end
          end
        endcase
      end
    end
  end

  // Read byte capture one cycle after the memory answers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      fetch2_q <= 1'b0;
      tx_q     <= READ_FILL;
    end else begin
      fetch2_q <= fetch_q;
      if (fetch2_q) begin
        tx_q <= below(idx_q, cur_len) ? mif.rdata
                                      : READ_FILL;
      end
    end
  end

  // Memory port: queued write wins, else read at the working index
  assign mif.addr  = wr_q ? wr_addr_q : phys(cur_loc, idx_q);
  assign mif.we    = wr_q;
  assign mif.wdata = wr_data_q;

  // Open-drain data line, enable low while pulling low
  assign o_sda_o    = 1'b0;
  assign o_sda_oe_n = !(((state_q == ST_ACK) && ack_q) ||
                        ((state_q == ST_TX) && !tx_q[~bit_q[2:0]]));
  assign o_busy     = (state_q != ST_IDLE) && (state_q != ST_WAIT);

  dab_mem u_mem (
    .i_clk       (i_clk),
    .bus         (mif.mem),
    .i_app_addr  (i_app_addr),
    .i_app_we    (i_app_we),
    .i_app_wdata (i_app_wdata),
    .o_app_rdata (o_app_rdata)
  );
endmodule
`default_nettype wire

// ### design/dab_pkg.sv
`default_nettype none
package dab_pkg;
  // Widths of the bus-side and memory-side quantities
  localparam int ADDR_W = 7;
  localparam int BYTE_W = 8;
  localparam int IDX_W  = 16;
  localparam int MEM_AW = 10;

  // Byte framing on the serial bus
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] LAST_BIT      = 3'h7;
  localparam int         RW_BIT_POS    = 0;

  // Byte returned for reads past the end of a buffer
  localparam logic [BYTE_W-1:0] READ_FILL = 8'hFF;
  localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [IDX_W-1:0]  IDX_ONE   = 16'h0001;

  // Which of the two buffers a transaction has selected
  localparam logic SEL_PRI = 1'b0;
  localparam logic SEL_SEC = 1'b1;

  // Bit-level sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK, ST_WAIT
  } dab_state_t;

  // Meaning of the next received byte
  typedef enum logic [1:0] {
    BK_ADDR, BK_SUB_HI, BK_SUB_LO, BK_DATA
  } dab_kind_t;
endpackage
`default_nettype wire

// ### design/dab_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dab_mem_if;
  import dab_pkg::*;
  logic [MEM_AW-1:0] addr;
  logic              we;
  logic [BYTE_W-1:0] wdata;
  logic [BYTE_W-1:0] rdata;

  // Bus sequencer side and memory side
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem  (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// ### design/dab_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dab_mem (
  input  wire logic                          i_clk,
  dab_mem_if.mem                             bus,
  input  wire logic [dab_pkg::MEM_AW-1:0]    i_app_addr,
  input  wire logic                          i_app_we,
  input  wire logic [dab_pkg::BYTE_W-1:0]    i_app_wdata,
  output logic      [dab_pkg::BYTE_W-1:0]    o_app_rdata
);
  import dab_pkg::*;

  localparam int DEPTH = 1 << MEM_AW;

  logic [BYTE_W-1:0] ram [DEPTH];

  // Shared storage; a bus write lands after an app write to the same byte
  always_ff @(posedge i_clk) begin
    if (i_app_we) begin
      ram[i_app_addr] <= i_app_wdata;
    end
    if (bus.we) begin
      ram[bus.addr] <= bus.wdata;
    end
  end

  // Registered read data on both ports
  always_ff @(posedge i_clk) begin
    bus.rdata   <= ram[bus.addr];
    o_app_rdata <= ram[i_app_addr];
  end
endmodule
`default_nettype wire

// ### tb/dab_i2c_slave_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dab_i2c_slave_monitor (
  input wire logic                       i_clk,
  input wire logic                       i_sys_rst,
  input wire logic                       i_scl,
  input wire logic                       i_sda,
  input wire logic                       o_sda_o,
  input wire logic                       o_sda_oe_n,
  input wire logic                       o_busy,
  input wire logic                       i_app_we,
  input wire logic [dab_pkg::MEM_AW-1:0] i_app_addr,
  input wire logic [dab_pkg::BYTE_W-1:0] i_app_wdata,
  input wire logic [dab_pkg::BYTE_W-1:0] o_app_rdata
);
  import dab_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Bus conditions on the pin levels
  sequence s_start;
    i_scl && $past(i_scl) && $fell(i_sda);
  endsequence
  sequence s_stop;
    i_scl && $past(i_scl) && $rose(i_sda);
  endsequence
  // Pin, idle and memory relations
  property p_sda_val;
    o_sda_o == 1'h0;
  endproperty
  property p_rst_idle;
    $fell(i_sys_rst) |-> o_sda_oe_n && !o_busy;
  endproperty
  property p_idle_rel;
    !o_busy |-> o_sda_oe_n;
  endproperty
  property p_edge_safe;
    $changed(o_sda_oe_n) |-> !i_scl;
  endproperty
  property p_no_fstart;
    s_start |-> o_sda_oe_n;
  endproperty
  property p_stop_free;
    s_stop |-> ##[1:8] !o_busy;
  endproperty
  property p_stop_rel;
    s_stop |=> o_sda_oe_n [*4];
  endproperty
  property p_app_rd;
    $past(i_app_we, 2) && !$past(i_app_we)
      && $past(i_app_addr, 2) == $past(i_app_addr)
      |-> o_app_rdata == $past(i_app_wdata, 2);
  endproperty
  // Busy only ever begins while the pins hold scl high and sda low
  property p_busy_start;
    $rose(o_busy) |-> i_scl && !i_sda;
  endproperty
  a_sda_val: assert property (p_sda_val)
    else $error("sda drive level not low");
  a_rst_idle: assert property (p_rst_idle)
    else $error("not idle after reset");
  a_idle_rel: assert property (p_idle_rel)
    else $error("sda pulled while not busy");
  a_edge_safe: assert property (p_edge_safe)
    else $error("sda drive moved while scl high");
  a_no_fstart: assert property (p_no_fstart)
    else $error("sda pulled at start");
  a_stop_free: assert property (p_stop_free)
    else $error("busy kept after stop");
  a_stop_rel: assert property (p_stop_rel)
    else $error("sda pulled after stop");
  a_app_rd: assert property (p_app_rd)
    else $error("app read data wrong");
  a_busy_start: assert property (p_busy_start)
    else $error("busy raised without a start");
endmodule
bind dab_i2c_slave dab_i2c_slave_monitor u_dab_i2c_slave_monitor (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_o(o_sda_o), .o_sda_oe_n(o_sda_oe_n), .o_busy(o_busy),
  .i_app_we(i_app_we), .i_app_addr(i_app_addr),
  .i_app_wdata(i_app_wdata), .o_app_rdata(o_app_rdata));
`default_nettype wire

// ### tb/dab_i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// Bus master; the bus clock stands high between frames
module dab_i2c_master_model (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output var logic  o_scl,
  output var logic  o_sda
);
  initial {o_scl, o_sda} = 2'h3;
  // Move both lines five clock edges after the last move
  task automatic step(input logic c, input logic d);
    repeat (5) @(posedge i_clk);
    o_scl <= c;
    o_sda <= d;
  endtask
  // Start, also usable as repeated start
  task automatic start();
    step(o_scl, 1'h1);
    step(1'h1, 1'h1);
    step(1'h1, 1'h0);
    step(1'h0, 1'h0);
  endtask
  task automatic stop();
    step(1'h0, 1'h0);
    step(1'h1, 1'h0);
    step(1'h1, 1'h1);
  endtask
  // One bit: data set mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    step(1'h0, b);
    step(1'h1, b);
    repeat (5) @(posedge i_clk);
    s = i_sda;
    step(1'h0, b);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'h1, s);
    ack = !s;
  endtask
  task automatic rd_byte(input logic nak, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'h1, d[i]);
    bit_io(nak, s);
  endtask
endmodule
`default_nettype wire

// ### tb/dab_i2c_slave_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dab_i2c_slave_tb_top;
  import dab_pkg::*;
  logic              clk, rst, two_en, sub16, str_en, nv_p, nv_s;
  logic [ADDR_W-1:0] a_pri, a_sec;
  logic [MEM_AW-1:0] loc_p, loc_s, app_addr;
  logic [IDX_W-1:0]  len_p, wl_p, len_s, wl_s;
  logic              app_we, sda_o, oe_n, busy;
  logic [BYTE_W-1:0] app_wd, app_rd;
  wire               scl, sda_m;
  int                n_fail, tests_run;
  // Open-drain data line with pull-up
  wire sda = sda_m & (oe_n | sda_o);
  dab_i2c_slave u_dab_i2c_slave (
    .i_clk(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe_n(oe_n), .i_addr_pri(a_pri),
    .i_addr_sec(a_sec), .i_two_addr_en(two_en), .i_sub_addr_16(sub16),
    .i_stretch_en(str_en), .i_pri_loc(loc_p), .i_pri_buffer_length(len_p),
    .i_pri_writable_region_length(wl_p), .i_pri_nonvolatile(nv_p),
    .i_sec_loc(loc_s), .i_sec_buffer_length(len_s),
    .i_sec_writable_region_length(wl_s), .i_sec_nonvolatile(nv_s),
    .i_app_addr(app_addr), .i_app_we(app_we), .i_app_wdata(app_wd),
    .o_app_rdata(app_rd), .o_busy(busy));
  dab_i2c_master_model u_dab_i2c_master_model (
    .i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_m));
  always #10 clk = ~clk;
  task automatic chk(input string n, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Local port write and read-back
  task automatic app_wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    {app_addr, app_we, app_wd} <= {a, 1'h1, d};
    @(posedge clk);
    app_we <= 1'h0;
  endtask
  task automatic mem_chk(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk);
    app_addr <= a;
    repeat (2) @(posedge clk);
    #1 chk("mem", e, app_rd);
  endtask
  // Bus write: address, index, data; ea holds expected acks
  task automatic wr_tx(input logic [6:0] a, input logic [15:0] x,
                       input int n, input logic [31:0] d, logic [4:0] ea);
    logic k;
    u_dab_i2c_master_model.start();
    u_dab_i2c_master_model.wr_byte({a, 1'h0}, k);
    chk("addr ack", {7'h0, ea[0]}, {7'h0, k});
    chk("busy", {7'h0, ea[0]}, {7'h0, busy});
    if (k === 1'h1) begin
      if (sub16) u_dab_i2c_master_model.wr_byte(x[15:8], k);
      u_dab_i2c_master_model.wr_byte(x[7:0], k);
      for (int i = 0; i < n; i++) begin
        u_dab_i2c_master_model.wr_byte(d[8*i +: 8], k);
        chk("data ack", {7'h0, ea[i+1]}, {7'h0, k});
        if (k !== 1'h1) break;
      end
    end
    u_dab_i2c_master_model.stop();
    // Stop is seen after the pin synchronisers
    repeat (4) @(posedge clk);
    chk("idle", 8'h00, {7'h0, busy});
  endtask
  task automatic rd_tx(input logic [6:0] a, input int n, logic [31:0] e);
    logic       k;
    logic [7:0] b;
    u_dab_i2c_master_model.start();
    u_dab_i2c_master_model.wr_byte({a, 1'h1}, k);
    chk("raddr ack", 8'h01, {7'h0, k});
    for (int i = 0; i < n; i++) begin
      u_dab_i2c_master_model.rd_byte(i == n - 1, b);
      chk("rd byte", e[8*i +: 8], b);
    end
    u_dab_i2c_master_model.stop();
  endtask
  // Write in the writable region, read back from the kept base
  task automatic sc_rw();
    wr_tx(7'h50, 16'h0002, 3, 32'h00332211, 5'h0F);
    mem_chk(10'h002, 8'h11);
    rd_tx(7'h50, 4, 32'hA5332211);
    rd_tx(7'h50, 1, 32'h00000011);
  endtask
  // Read-only writes with both answer styles, past-end write with the ACK style
  task automatic sc_bound();
    @(posedge clk);
    str_en <= 1'h1;
    wr_tx(7'h50, 16'h0005, 2, 32'h00007766, 5'h03);
    mem_chk(10'h005, 8'h66);
    mem_chk(10'h006, 8'hA6);
    @(posedge clk);
    str_en <= 1'h0;
    wr_tx(7'h50, 16'h0009, 2, 32'h00009988, 5'h07);
    mem_chk(10'h009, 8'hA9);
    mem_chk(10'h00A, 8'hAA);
    rd_tx(7'h50, 3, 32'h00FFFFA9);
  endtask
  // Second address, two-byte index, non-volatile, disabled
  task automatic sc_sec();
    @(posedge clk);
    {two_en, sub16, str_en} <= 3'h7;
    wr_tx(7'h05, 16'h0001, 1, 32'h5D, 5'h03);
    mem_chk(10'h101, 8'h5D);
    wr_tx(7'h05, 16'h0100, 1, 32'h77, 5'h01);
    mem_chk(10'h100, 8'hC0);
    rd_tx(7'h50, 1, 32'hA9);
    @(posedge clk);
    nv_s <= 1'h1;
    wr_tx(7'h05, 16'h0000, 1, 32'h77, 5'h01);
    mem_chk(10'h100, 8'hC0);
    rd_tx(7'h05, 2, 32'h00005DC0);
    @(posedge clk);
    two_en <= 1'h0;
    wr_tx(7'h05, 16'h0000, 0, 32'h0, 5'h00);
  endtask
  // Main sequence
  initial begin
    clk = 1'h0;
    rst = 1'h1;
    {two_en, sub16, str_en, nv_p, nv_s, app_we} = 6'h0;
    {a_pri, a_sec} = {7'h50, 7'h05};
    {loc_p, loc_s, app_addr, app_wd} = {10'h000, 10'h100, 10'h000, 8'h00};
    {len_p, wl_p, len_s, wl_s} = {16'hA, 16'h6, 16'h4, 16'h4};
    n_fail = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 16; i++) begin
      app_wr(i[9:0], 8'hA0 + i[7:0]);
      app_wr(10'h100 + i[9:0], 8'hC0 + i[7:0]);
    end
    sc_rw();
    sc_bound();
    sc_sec();
    wrap_up();
  end
endmodule
`default_nettype wire
